// ===== hdl/seek_tune_pkg.sv
// Overview of operation
// R1: report format bit: 0 standard, 1 verbose
// R2: limit bit 0: wrap at edges, continue
// R3: limit bit 1: stop seek at edge
// R4: direction bit: 0 steps down, 1 up
// R5: seek starts at current channel, chosen direction
// R6: seek ends: valid, band scanned, or edge
// R7: end raises complete; fail when none found
// R8: dropping seek bit clears complete and fail
// R9: writing seek bit zero aborts the search
// R10: tune bit 15 starts tune, resets zero
// R11: tune completion raises complete flag
// R12: dropping tune bit clears complete flag
// R13: band 00: spacing times channel plus 87.5
// R14: band 01/10: spacing times channel plus 76
// R15: band 11: spacing times channel plus 64
// R16: spacing bits 5:4, band bits 7:6
// R17: station number untouched during seek
// R18: current station tracks seek, holds result
// R19: host writes zeros to reserved bits
// R20: power enable bit 0, disable bit 6
// R21: enabled pin2 irq gives 5 ms low
// R22: requests ignored while complete flag set
package seek_tune_pkg;

  localparam int unsigned REF_CLK_KHZ = 25000;
  localparam int unsigned REG_W       = 16;
  localparam int unsigned CHAN_W      = 10;
  localparam int unsigned FREQ_W      = 19;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER_CFG      = 8'h02;
  localparam logic [7:0] IDX_STATION_TUNING = 8'h03;
  localparam logic [7:0] IDX_SYS_CFG1       = 8'h04;
  localparam logic [7:0] IDX_SYS_CFG2       = 8'h05;
  localparam logic [7:0] IDX_STATUS         = 8'h0A;
  localparam logic [7:0] ADDR_POWER_CFG      = {IDX_POWER_CFG[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATION_TUNING = {IDX_STATION_TUNING[5:0], 2'b00};
  localparam logic [7:0] ADDR_SYS_CFG1       = {IDX_SYS_CFG1[5:0], 2'b00};
  localparam logic [7:0] ADDR_SYS_CFG2       = {IDX_SYS_CFG2[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS         = {IDX_STATUS[5:0], 2'b00};

  // reset values
  localparam logic [15:0] RST_POWER_CFG      = 16'h0000;
  localparam logic [15:0] RST_STATION_TUNING = 16'h0000;
  localparam logic [15:0] RST_SYS_CFG1       = 16'h0000;
  localparam logic [15:0] RST_SYS_CFG2       = 16'h0000;

  // field positions
  localparam int unsigned PWR_ENABLE_BIT   = 0;
  localparam int unsigned PWR_DISABLE_BIT  = 6;
  localparam int unsigned SEEK_REQ_BIT     = 8;
  localparam int unsigned SEARCH_DIR_BIT   = 9;
  localparam int unsigned SEEK_LIMIT_BIT   = 10;
  localparam int unsigned RDS_FORMAT_BIT   = 11;
  localparam int unsigned TUNE_REQ_BIT     = 15;
  localparam int unsigned IRQ_ENABLE_BIT   = 14;
  localparam int unsigned PIN2_FN_LSB      = 2;
  localparam int unsigned SPACING_LSB      = 4;
  localparam int unsigned BAND_LSB         = 6;
  localparam int unsigned THRESH_LSB       = 8;
  localparam int unsigned COMPLETE_BIT     = 14;
  localparam int unsigned FAIL_BIT         = 13;

  // band edges and channel steps in kHz
  localparam int unsigned BASE_KHZ_BAND0 = 87500;
  localparam int unsigned BASE_KHZ_BAND12 = 76000;
  localparam int unsigned BASE_KHZ_BAND3 = 64000;
  localparam int unsigned TOP_KHZ_BAND0  = 108000;
  localparam int unsigned TOP_KHZ_BAND1  = 108000;
  localparam int unsigned TOP_KHZ_BAND2  = 90000;
  localparam int unsigned TOP_KHZ_BAND3  = 76000;
  localparam int unsigned SPACE_KHZ_0    = 200;
  localparam int unsigned SPACE_KHZ_1    = 100;
  localparam int unsigned SPACE_KHZ_2    = 50;

  // timing
  localparam int unsigned SETTLE_US        = 60;
  localparam int unsigned SETTLE_CYCLES    = (SETTLE_US * REF_CLK_KHZ + 999) / 1000;
  localparam int unsigned IRQ_PULSE_MS     = 5;
  localparam int unsigned IRQ_PULSE_CYCLES = IRQ_PULSE_MS * REF_CLK_KHZ;

  // general pin 2 function codes
  localparam logic [1:0] PIN2_HIZ  = 2'h0;
  localparam logic [1:0] PIN2_IRQ  = 2'h1;
  localparam logic [1:0] PIN2_LOW  = 2'h2;
  localparam logic [1:0] PIN2_HIGH = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_STEP   = 2'b01,
    ST_SETTLE = 2'b10,
    ST_CHECK  = 2'b11
  } tuner_state_t;

  typedef struct packed {
    logic seek_req;
    logic search_direction;
    logic seek_limit_behaviour;
    logic rds_report_format;
  } seek_cfg_t;

  typedef struct packed {
    logic [7:0] threshold;
    logic [1:0] band;
    logic [1:0] spacing;
  } band_cfg_t;

endpackage

// ===== hdl/seek_tune_control.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module seek_tune_control #(
  parameter int unsigned IRQ_PULSE_CYCLES = seek_tune_pkg::IRQ_PULSE_CYCLES
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic [2:0]  s_axi_awprot_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic [2:0]  s_axi_arprot_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic [7:0]  rssi_in,
  output logic [18:0]      tuned_freq_khz_out,
  output logic             retune_strobe_out,
  output logic             seek_busy_out,
  output logic             rds_report_format_out,
  output logic             power_enable_out,
  output logic             power_disable_out,
  output logic             general_pin2_out,
  output logic             general_pin2_oe_out
);

  localparam int unsigned PULSE_W = $clog2(IRQ_PULSE_CYCLES + 1);
  localparam int unsigned SETTLE_W = $clog2(seek_tune_pkg::SETTLE_CYCLES + 1);

  // register storage
  logic [15:0] power_cfg_r;
  logic [15:0] station_tuning_r;
  logic [15:0] sys_cfg1_r;
  logic [15:0] sys_cfg2_r;

  // bus slave state
  logic        aw_full_r;
  logic        w_full_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_en;
  logic        wr_hit;
  logic [31:0] rd_data;
  logic        rd_hit;

  // tuner state
  seek_tune_pkg::tuner_state_t state_r;
  seek_tune_pkg::seek_cfg_t    seek_cfg;
  seek_tune_pkg::band_cfg_t    band_cfg;
  logic [9:0]          cur_ch_r;
  logic [9:0]          start_ch_r;
  logic                op_is_seek_r;
  logic [SETTLE_W-1:0] settle_cnt_r;
  logic                op_complete_flag_r;
  logic                search_fail_flag_r;
  logic                finish;
  logic                finish_fail;
  logic                tune_req;
  logic                clear_flags;
  logic                start_seek;
  logic                start_tune;
  logic                abort;
  logic [9:0]          top_ch;
  logic [9:0]          next_ch;
  logic                at_edge;
  logic [PULSE_W-1:0]  pulse_cnt_r;

  // highest channel that still lies inside the band
  function automatic logic [9:0] top_channel(input logic [1:0] band, input logic [1:0] space);
    int unsigned span;
    span = seek_tune_pkg::TOP_KHZ_BAND0 - seek_tune_pkg::BASE_KHZ_BAND0;
    case (band)
      2'b01: span = seek_tune_pkg::TOP_KHZ_BAND1 - seek_tune_pkg::BASE_KHZ_BAND12;
      2'b10: span = seek_tune_pkg::TOP_KHZ_BAND2 - seek_tune_pkg::BASE_KHZ_BAND12;
      2'b11: span = seek_tune_pkg::TOP_KHZ_BAND3 - seek_tune_pkg::BASE_KHZ_BAND3;
      default: span = seek_tune_pkg::TOP_KHZ_BAND0 - seek_tune_pkg::BASE_KHZ_BAND0;
    endcase
    case (space)
      2'b00: top_channel = 10'(span / seek_tune_pkg::SPACE_KHZ_0);
      2'b01: top_channel = 10'(span / seek_tune_pkg::SPACE_KHZ_1);
      default: top_channel = 10'(span / seek_tune_pkg::SPACE_KHZ_2);
    endcase
  endfunction

  // channel to frequency; undefined spacing code 11 falls back to the finest step
  function automatic logic [18:0] chan_freq(input logic [1:0] band, input logic [1:0] space,
                                            input logic [9:0] ch);
    int unsigned base;
    int unsigned step;
    case (band)
      2'b00: base = seek_tune_pkg::BASE_KHZ_BAND0;    // [R13]
      2'b01, 2'b10: base = seek_tune_pkg::BASE_KHZ_BAND12; // [R14]
      default: base = seek_tune_pkg::BASE_KHZ_BAND3;  // [R15]
    endcase
    case (space)
      2'b00: step = seek_tune_pkg::SPACE_KHZ_0;
      2'b01: step = seek_tune_pkg::SPACE_KHZ_1;
      default: step = seek_tune_pkg::SPACE_KHZ_2;
    endcase
    chan_freq = 19'(base + step * int'(ch));
  endfunction

  // merge written byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  // field views of the configuration registers
  assign seek_cfg.seek_req             = power_cfg_r[seek_tune_pkg::SEEK_REQ_BIT];
  assign seek_cfg.search_direction     = power_cfg_r[seek_tune_pkg::SEARCH_DIR_BIT];
  assign seek_cfg.seek_limit_behaviour = power_cfg_r[seek_tune_pkg::SEEK_LIMIT_BIT];
  assign seek_cfg.rds_report_format    = power_cfg_r[seek_tune_pkg::RDS_FORMAT_BIT];
  assign band_cfg.threshold = sys_cfg2_r[seek_tune_pkg::THRESH_LSB +: 8];
  assign band_cfg.band      = sys_cfg2_r[seek_tune_pkg::BAND_LSB +: 2];    // [R16]
  assign band_cfg.spacing   = sys_cfg2_r[seek_tune_pkg::SPACING_LSB +: 2]; // [R16]
  assign tune_req = station_tuning_r[seek_tune_pkg::TUNE_REQ_BIT];

  // write happens once address and data are both held
  assign wr_en  = aw_full_r && w_full_r && !s_axi_bvalid_out;
  assign wr_hit = (aw_addr_r == seek_tune_pkg::ADDR_POWER_CFG) ||
                  (aw_addr_r == seek_tune_pkg::ADDR_STATION_TUNING) ||
                  (aw_addr_r == seek_tune_pkg::ADDR_SYS_CFG1) ||
                  (aw_addr_r == seek_tune_pkg::ADDR_SYS_CFG2);

  // write address and data channels, taken in either order
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_full_r         <= 1'b0;
      w_full_r          <= 1'b0;
      aw_addr_r         <= 8'h00;
      w_data_r          <= 32'h0000_0000;
      w_strb_r          <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= seek_tune_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full_r         <= 1'b1;
        aw_addr_r         <= {s_axi_awaddr_in[7:2], 2'b00};
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full_r         <= 1'b1;
        w_data_r         <= s_axi_wdata_in;
        w_strb_r         <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_en) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_hit ? seek_tune_pkg::RESP_OKAY : seek_tune_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        aw_full_r         <= 1'b0;
        w_full_r          <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // software-visible registers; the status word is read-only
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      power_cfg_r      <= seek_tune_pkg::RST_POWER_CFG;      // [R20] [R1] [R2] [R4]
      station_tuning_r <= seek_tune_pkg::RST_STATION_TUNING; // [R10]
      sys_cfg1_r       <= seek_tune_pkg::RST_SYS_CFG1;
      sys_cfg2_r       <= seek_tune_pkg::RST_SYS_CFG2;
    end else if (wr_en) begin
      // reserved bits are stored as written; zero is the host's job
      case (aw_addr_r)
        seek_tune_pkg::ADDR_POWER_CFG: begin
          power_cfg_r <= merge16(power_cfg_r, w_data_r, w_strb_r);
        end
        seek_tune_pkg::ADDR_STATION_TUNING: begin
          station_tuning_r <= merge16(station_tuning_r, w_data_r, w_strb_r);
        end
        seek_tune_pkg::ADDR_SYS_CFG1: begin
          sys_cfg1_r <= merge16(sys_cfg1_r, w_data_r, w_strb_r);
        end
        seek_tune_pkg::ADDR_SYS_CFG2: begin
          sys_cfg2_r <= merge16(sys_cfg2_r, w_data_r, w_strb_r);
        end
        default: begin
        end
      endcase
    end
  end

  // read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case ({s_axi_araddr_in[7:2], 2'b00})
      seek_tune_pkg::ADDR_POWER_CFG:      rd_data = {16'h0000, power_cfg_r};
      seek_tune_pkg::ADDR_STATION_TUNING: rd_data = {16'h0000, station_tuning_r};
      seek_tune_pkg::ADDR_SYS_CFG1:       rd_data = {16'h0000, sys_cfg1_r};
      seek_tune_pkg::ADDR_SYS_CFG2:       rd_data = {16'h0000, sys_cfg2_r};
      seek_tune_pkg::ADDR_STATUS: begin
        rd_data[seek_tune_pkg::COMPLETE_BIT] = op_complete_flag_r;
        rd_data[seek_tune_pkg::FAIL_BIT]     = search_fail_flag_r;
        rd_data[9:0]                         = cur_ch_r; // [R18]
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= seek_tune_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_data;
      s_axi_rresp_out   <= rd_hit ? seek_tune_pkg::RESP_OKAY : seek_tune_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // request decode; a raised complete flag blocks any new start
  assign start_seek = (state_r == seek_tune_pkg::ST_IDLE) && !op_complete_flag_r &&
                      seek_cfg.seek_req; // [R22] [R5]
  assign start_tune = (state_r == seek_tune_pkg::ST_IDLE) && !op_complete_flag_r &&
                      !seek_cfg.seek_req && tune_req; // [R22] [R10]
  assign abort = (state_r != seek_tune_pkg::ST_IDLE) && op_is_seek_r &&
                 !seek_cfg.seek_req; // [R9]
  assign top_ch = top_channel(band_cfg.band, band_cfg.spacing);

  // next channel and band edge test for one seek step
  always_comb begin
    next_ch = cur_ch_r;
    at_edge = 1'b0;
    if (seek_cfg.search_direction) begin // [R4]
      if (cur_ch_r >= top_ch) begin
        at_edge = 1'b1;
        next_ch = 10'h000; // [R2]
      end else begin
        next_ch = cur_ch_r + 10'h001;
      end
    end else begin
      if (cur_ch_r == 10'h000) begin
        at_edge = 1'b1;
        next_ch = top_ch; // [R2]
      end else begin
        next_ch = cur_ch_r - 10'h001;
      end
    end
  end

  // end of operation decode
  always_comb begin
    finish      = 1'b0;
    finish_fail = 1'b0;
    if (!abort) begin
      if (state_r == seek_tune_pkg::ST_STEP) begin
        if (at_edge && seek_cfg.seek_limit_behaviour) begin
          finish      = 1'b1; // [R3] [R6]
          finish_fail = 1'b1;
        end else if (next_ch == start_ch_r) begin
          finish      = 1'b1; // [R6]
          finish_fail = 1'b1;
        end
      end else if (state_r == seek_tune_pkg::ST_CHECK) begin
        finish = !op_is_seek_r || (rssi_in >= band_cfg.threshold); // [R6] [R11]
      end
    end
  end

  // tuner sequencing: step, settle, judge
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r            <= seek_tune_pkg::ST_IDLE;
      cur_ch_r           <= 10'h000;
      start_ch_r         <= 10'h000;
      op_is_seek_r       <= 1'b0;
      settle_cnt_r       <= '0;
      tuned_freq_khz_out <= 19'h00000;
      retune_strobe_out  <= 1'b0;
    end else begin
      retune_strobe_out <= 1'b0;
      if (abort || finish) begin
        state_r <= seek_tune_pkg::ST_IDLE; // [R9]
      end else begin
        case (state_r)
          seek_tune_pkg::ST_IDLE: begin
            if (start_seek) begin
              op_is_seek_r <= 1'b1;
              start_ch_r   <= cur_ch_r; // [R5]
              state_r      <= seek_tune_pkg::ST_STEP;
            end else if (start_tune) begin
              op_is_seek_r       <= 1'b0;
              cur_ch_r           <= station_tuning_r[9:0]; // [R10] [R18]
              tuned_freq_khz_out <= chan_freq(band_cfg.band, band_cfg.spacing,
                                              station_tuning_r[9:0]); // [R13]
              retune_strobe_out  <= 1'b1;
              settle_cnt_r       <= '0;
              state_r            <= seek_tune_pkg::ST_SETTLE;
            end
          end
          seek_tune_pkg::ST_STEP: begin
            // station number register stays as written; only the readback moves
            cur_ch_r           <= next_ch; // [R17] [R18]
            tuned_freq_khz_out <= chan_freq(band_cfg.band, band_cfg.spacing, next_ch);
            retune_strobe_out  <= 1'b1;
            settle_cnt_r       <= '0;
            state_r            <= seek_tune_pkg::ST_SETTLE;
          end
          seek_tune_pkg::ST_SETTLE: begin
            if (settle_cnt_r == SETTLE_W'(seek_tune_pkg::SETTLE_CYCLES - 1)) begin
              state_r <= seek_tune_pkg::ST_CHECK;
            end else begin
              settle_cnt_r <= settle_cnt_r + 1'b1;
            end
          end
          seek_tune_pkg::ST_CHECK: begin
            state_r <= seek_tune_pkg::ST_STEP; // weak channel, keep searching
          end
          default: begin
            state_r <= seek_tune_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // flags are cleared by dropping the request of the finished operation
  assign clear_flags = op_complete_flag_r &&
                       (op_is_seek_r ? !seek_cfg.seek_req : !tune_req); // [R8] [R12]

  // completion and fail flags; a new set wins over a clear
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      op_complete_flag_r <= 1'b0;
      search_fail_flag_r <= 1'b0;
    end else if (finish) begin
      op_complete_flag_r <= 1'b1;        // [R7] [R11]
      search_fail_flag_r <= finish_fail; // [R7]
    end else if (clear_flags) begin
      op_complete_flag_r <= 1'b0; // [R8] [R12]
      search_fail_flag_r <= 1'b0;
    end
  end

  // general pin 2; low pulse counter armed on completion
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pulse_cnt_r         <= '0;
      general_pin2_out    <= 1'b1;
      general_pin2_oe_out <= 1'b0;
    end else begin
      if (finish && !op_complete_flag_r && sys_cfg1_r[seek_tune_pkg::IRQ_ENABLE_BIT] &&
          sys_cfg1_r[seek_tune_pkg::PIN2_FN_LSB +: 2] == seek_tune_pkg::PIN2_IRQ) begin
        pulse_cnt_r <= PULSE_W'(IRQ_PULSE_CYCLES); // [R21]
      end else if (pulse_cnt_r != '0) begin
        pulse_cnt_r <= pulse_cnt_r - 1'b1;
      end
      case (sys_cfg1_r[seek_tune_pkg::PIN2_FN_LSB +: 2])
        seek_tune_pkg::PIN2_IRQ: begin
          general_pin2_oe_out <= 1'b1;
          // output lags the counter by one edge; pulse width stays exact
          general_pin2_out    <= (pulse_cnt_r == '0); // [R21]
        end
        seek_tune_pkg::PIN2_LOW: begin
          general_pin2_oe_out <= 1'b1;
          general_pin2_out    <= 1'b0;
        end
        seek_tune_pkg::PIN2_HIGH: begin
          general_pin2_oe_out <= 1'b1;
          general_pin2_out    <= 1'b1;
        end
        default: begin
          general_pin2_oe_out <= 1'b0;
          general_pin2_out    <= 1'b1;
        end
      endcase
    end
  end

  // busy indication for the receiver
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seek_busy_out <= 1'b0;
    end else begin
      seek_busy_out <= start_seek || (op_is_seek_r && state_r != seek_tune_pkg::ST_IDLE &&
                                      !abort && !finish);
    end
  end

  // plain configuration outputs taken straight from register bits
  assign rds_report_format_out = power_cfg_r[seek_tune_pkg::RDS_FORMAT_BIT];  // [R1]
  assign power_enable_out      = power_cfg_r[seek_tune_pkg::PWR_ENABLE_BIT];  // [R20]
  assign power_disable_out     = power_cfg_r[seek_tune_pkg::PWR_DISABLE_BIT]; // [R20]

endmodule
`default_nettype wire

// ===== bench/seek_tune_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module seek_tune_monitor (
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic [18:0] tuned_freq_khz_out,
  input wire logic        retune_strobe_out,
  input wire logic        seek_busy_out,
  input wire logic        rds_report_format_out,
  input wire logic        power_enable_out,
  input wire logic        power_disable_out,
  input wire logic        general_pin2_out,
  input wire logic        general_pin2_oe_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // both halves of a write taken on one edge
  sequence wr_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  wr_answer_a: assert property (wr_taken |=> ##1 s_axi_bvalid_out)
    else $error("write response late");
  wr_release_a: assert property (s_axi_bvalid_out && s_axi_bready_in
    |=> !s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out)
    else $error("write channels not reopened");
  rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data late");
  // config outputs move only with a write response
  cfg_update_a: assert property ($changed({rds_report_format_out, power_enable_out,
    power_disable_out}) |-> $rose(s_axi_bvalid_out)) else $error("config changed unasked");
  freq_strobe_a: assert property ($changed(tuned_freq_khz_out) |-> retune_strobe_out)
    else $error("frequency moved without strobe");
  seek_start_a: assert property ($rose(seek_busy_out)
    |-> ##[0:2] (retune_strobe_out || !seek_busy_out)) else $error("seek did not step");
  step_settle_a: assert property (retune_strobe_out && seek_busy_out
    |=> !retune_strobe_out [*8]) else $error("seek stepped without settling");
  irq_pulse_a: assert property ($fell(general_pin2_out) && general_pin2_oe_out
    |=> !general_pin2_out [*8]) else $error("pin pulse too short");
endmodule
bind seek_tune_control seek_tune_monitor u_mon (.*);
`default_nettype wire

// ===== bench/rssi_model.sv
`timescale 1ns/1ps
`default_nettype none
module rssi_model (
  input  wire logic [18:0] freq_khz_in,
  input  wire logic [18:0] strong_khz_in,
  output logic      [7:0]  rssi_out
);
  // one strong carrier; every other channel sits under the threshold
  assign rssi_out = (freq_khz_in == strong_khz_in) ? 8'hF0 : 8'h10;
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] A_PW = seek_tune_pkg::ADDR_POWER_CFG;
  localparam logic [7:0] A_CH = seek_tune_pkg::ADDR_STATION_TUNING;
  localparam logic [7:0] A_ST = seek_tune_pkg::ADDR_STATUS;
  localparam int BASE [4] = '{87500, 76000, 76000, 64000};
  logic ref_clk_in, reset_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, retune_strobe_out;
  logic seek_busy_out, rds_report_format_out, power_enable_out, power_disable_out;
  logic general_pin2_out, general_pin2_oe_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rsp;
  logic [2:0]  s_axi_awprot_in, s_axi_arprot_in;
  logic [3:0]  s_axi_wstrb_in;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, rssi_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [18:0] tuned_freq_khz_out, strong_khz;
  logic [15:0] st, d;
  int          error_cnt = 0, check_count = 0;

  // short pin pulse keeps the run brief
  seek_tune_control #(.IRQ_PULSE_CYCLES(20)) u_dut (.*);
  rssi_model u_rssi (.freq_khz_in(tuned_freq_khz_out), .strong_khz_in(strong_khz),
    .rssi_out(rssi_in));

  always #20 ref_clk_in = ~ref_clk_in;

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, s);
    end
  endtask

  task wr(input logic [7:0] a, input logic [15:0] v);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {16'h0000, v};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    rsp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task rd(input logic [7:0] a);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out);
    d = s_axi_rdata_out[15:0];
    rsp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task wait_flag;
    d = 16'h0000;
    for (int i = 0; i < 4000 && !d[14]; i++) rd(A_ST);
    st = d;
  endtask

  task tune(input logic [9:0] ch);
    wr(A_CH, {6'h20, ch});
    wait_flag();
    wr(A_CH, {6'h00, ch});
  endtask

  task t_cfg;
    rd(A_PW);
    chk("power reset", d, 16'h0000);
    rd(A_CH);
    chk("tuning reset", d, 16'h0000);
    wr(A_PW, 16'h0841);
    chk("format", rds_report_format_out, 1'b1);
    chk("power bits", {power_enable_out, power_disable_out}, 2'b11);
    rd(8'h3C);
    chk("unmapped", rsp, seek_tune_pkg::RESP_SLVERR);
    wr(A_ST, 16'h0000);
    chk("status write", rsp, seek_tune_pkg::RESP_SLVERR);
    wr(A_PW, 16'h0001);
    chk("format off", rds_report_format_out, 1'b0);
  endtask

  task t_tune;
    wr(seek_tune_pkg::ADDR_SYS_CFG1, 16'h4004);
    for (int b = 0; b < 4; b++) begin
      wr(seek_tune_pkg::ADDR_SYS_CFG2, 16'h8010 | (16'(b) << 6));
      tune(10'd10);
      chk("freq", tuned_freq_khz_out, BASE[b] + 1000);
      chk("tune status", {st[14], st[9:0]}, {1'b1, 10'd10});
      rd(A_ST);
      chk("tune cleared", d[14], 1'b0);
    end
  endtask

  task t_seek_up;
    wr(seek_tune_pkg::ADDR_SYS_CFG2, 16'h8010);
    tune(10'd10);
    wr(A_PW, 16'h0301);
    wait_flag();
    chk("seek up", {st[14:13], st[9:0]}, {2'b10, 10'd15});
    rd(A_CH);
    chk("number kept", d, 16'h000A);
    wr(A_PW, 16'h0001);
    rd(A_ST);
    chk("seek cleared", d[14:13], 2'b00);
  endtask

  task t_seek_edges;
    tune(10'd2);
    wr(A_PW, 16'h0501);
    wait_flag();
    chk("seek stop", {st[14:13], st[9:0]}, {2'b11, 10'd0});
    wr(A_PW, 16'h0001);
    strong_khz <= 19'd108000;
    wr(A_PW, 16'h0101);
    wait_flag();
    chk("seek wrap", {st[14:13], st[9:0]}, {2'b10, 10'd205});
    wr(A_PW, 16'h0001);
  endtask

  task t_abort;
    strong_khz <= 19'd0;
    wr(A_PW, 16'h0101);
    repeat (300) @(posedge ref_clk_in);
    chk("busy", seek_busy_out, 1'b1);
    wr(A_PW, 16'h0001);
    rd(A_ST);
    chk("abort", {seek_busy_out, d[14:13]}, 3'b000);
  endtask

  task final_report;
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    {ref_clk_in, reset_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
    {s_axi_arvalid_in, s_axi_rready_in, s_axi_awprot_in, s_axi_arprot_in} = '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    s_axi_wstrb_in = 4'hF;
    strong_khz = 19'd89000;
    repeat (20) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(posedge ref_clk_in);
    t_cfg();
    t_tune();
    t_seek_up();
    t_seek_edges();
    t_abort();
    final_report();
  end

  // whole run needs about 22k cycles
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
